// File: hdl/ibc_ctrl.sv
// Function
// - Writing the count register returns the buffer pointer to location zero, except in a cycle where a serial byte ends.
// - On completion the count register holds bytes actually sent or received.
// - Transmit sequences send buffer location zero first.
// - Receive completion returns the pointer to the first received byte.
// - Count zero or above 68 transfers nothing, interrupts, status FCh.
// - Count register: length in bits 6:0, last-byte-nack flag in bit 7.
// - Master transmit count is 1 after address, n+1 after n data.
// - Arbitration loss: 0 in address, else bytes completed before loss.
// - Master receive count: 1 on address nack, n after n bytes.
// - Address and sub-address sent and acked: hold clock, interrupt, 28h.
// - Start request while owning the bus: repeated start, interrupt, 10h.
// - Receive ending with last byte acked: hold clock, interrupt, 50h.
// - Receive ending with last byte nacked: interrupt, 58h, hold clock.
// - Stop-only control write sends stop, no interrupt, status F8h.
// - Last received byte is nacked when the flag is set, else acked.
// - Buffer holds 68 bytes and the pointer wraps to location zero.
`timescale 1ns/1ns
module ibc_ctrl (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire ibc_pkg::ibc_req_t req,
    output logic [7:0]             rd_data,
    output logic                   irq,
    input  wire logic              scl_i,
    output logic                   scl_o,
    output logic                   scl_oe_n,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe_n
);
    import ibc_pkg::*;

    logic [7:0] buf_q [BUF_DEPTH];
    logic [6:0] ptr_q;
    logic [7:0] count_q;
    logic [7:0] status_q;
    logic [7:0] rd_data_q;
    logic       si_q;
    logic       mode_q;
    ibc_state_t state_q;
    logic [4:0] tmr_q;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic [6:0] done_q;
    logic       nack_q;
    logic       own_q;
    logic       rx_q;
    logic       addr_q;
    logic       scl_oen_q;
    logic       sda_oen_q;
    logic       scl_m_q;
    logic       scl_s_q;
    logic       sda_m_q;
    logic       sda_s_q;
    logic       fin;
    logic       fin_cnt_en;
    logic [7:0] fin_sts;
    logic [6:0] fin_cnt;

    function automatic logic [6:0] ptr_next(input logic [6:0] p);
        return (p == BUF_LAST) ? 7'h00 : p + 7'h01;
    endfunction

    function automatic logic hit(input ibc_req_t r, input logic [1:0] ofs);
        return r.addr == ofs;
    endfunction

    wire ready      = (state_q == S_IDLE) || (state_q == S_HOLD);
    wire active     = !ready;
    wire host_cnt   = req.wr && hit(req, OFS_COUNT);
    wire host_ctl   = req.wr && hit(req, OFS_CTRL);
    wire data_acc   = (req.wr || req.rd) && hit(req, OFS_DATA);
    wire cmd_sta    = host_ctl && ready && req.wdata[CTL_STA];
    wire cmd_sto    = host_ctl && ready && !req.wdata[CTL_STA]
                      && req.wdata[CTL_STO];
    wire cmd_go     = host_ctl && ready && own_q && !req.wdata[CTL_STA]
                      && !req.wdata[CTL_STO] && !req.wdata[CTL_SI]
                      && req.wdata[CTL_MODE];
    wire bad_cnt    = (count_q[6:0] == 7'h00) || (count_q[6:0] > CNT_MAX);
    wire launch     = cmd_go && !bad_cnt;
    wire tick       = tmr_q == QTR_LAST;
    wire step       = tick && !(ph_q == 2'h2 && !scl_s_q);
    wire at_bit     = (state_q == S_BIT) && step;
    wire byte_end   = at_bit && ph_q == 2'h3 && bit_q == 4'h8;
    wire last_byte  = 7'(done_q + 7'h01) == count_q[6:0];
    wire to_rx      = !rx_q && addr_q && shift_q[0] && !nack_q;
    wire start_done = (state_q == S_START) && step && ph_q == 2'h3;
    wire stop_done  = (state_q == S_STOP) && step && ph_q == 2'h3;
    wire we_drive   = (!rx_q && bit_q != 4'h8) || (rx_q && bit_q == 4'h8);
    wire lost       = at_bit && ph_q == 2'h2 && sda_oen_q && !sda_s_q
                      && we_drive;
    wire drv_low    = (!rx_q && bit_q != 4'h8 && !shift_q[7])
                      || (rx_q && bit_q == 4'h8
                          && !(last_byte && count_q[CNT_LB]));

    assign rd_data  = rd_data_q;
    assign irq      = si_q;
    assign scl_oe_n = scl_oen_q;
    assign sda_oe_n = sda_oen_q;
    assign scl_o    = 1'b0;
    assign sda_o    = 1'b0;

    // Two-flop synchronisers for the serial pins.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
        end
        else
        begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
        end
    end

    // Completion events and the values they load.
    always_comb
    begin
        fin        = 1'b0;
        fin_cnt_en = 1'b0;
        fin_sts    = status_q;
        fin_cnt    = done_q;
        if (cmd_go && bad_cnt)
        begin
            fin     = 1'b1;
            fin_sts = STS_BAD_COUNT;
        end
        else if (start_done)
        begin
            fin     = 1'b1;
            fin_sts = own_q ? STS_RESTART : STS_START;
        end
        else if (lost)
        begin
            fin        = 1'b1;
            fin_cnt_en = 1'b1;
            fin_sts    = STS_ARB_LOST;
            fin_cnt    = 7'(done_q + {6'h00, rx_q});
        end
        else if (byte_end)
        begin
            fin_cnt = 7'(done_q + 7'h01);
            if (rx_q)
            begin
                if (last_byte)
                begin
                    fin        = 1'b1;
                    fin_cnt_en = 1'b1;
                    fin_sts    = count_q[CNT_LB] ? STS_RX_NACK
                                                 : STS_RX_ACK;
                end
            end
            else if (nack_q)
            begin
                fin        = 1'b1;
                fin_cnt_en = 1'b1;
                if (!addr_q)
                begin
                    fin_sts = STS_DATA_NACK;
                end
                else
                begin
                    fin_sts = shift_q[0] ? STS_RADR_NACK : STS_ADDR_NACK;
                end
            end
            else if (!to_rx && last_byte)
            begin
                fin        = 1'b1;
                fin_cnt_en = 1'b1;
                fin_sts    = addr_q ? STS_ADDR_ACK : STS_DATA_ACK;
            end
        end
    end

    // Serial engine.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_q   <= S_IDLE;
            tmr_q     <= 5'h00;
            ph_q      <= 2'h0;
            bit_q     <= 4'h0;
            shift_q   <= 8'h00;
            done_q    <= 7'h00;
            nack_q    <= 1'b0;
            own_q     <= 1'b0;
            rx_q      <= 1'b0;
            addr_q    <= 1'b0;
            scl_oen_q <= 1'b1;
            sda_oen_q <= 1'b1;
        end
        else
        begin
            tmr_q <= (!active || tick) ? 5'h00 : 5'(tmr_q + 5'h01);
            if (active && step)
            begin
                ph_q <= 2'(ph_q + 2'h1);
            end
            unique case (state_q)
                S_IDLE, S_HOLD:
                begin
                    ph_q <= 2'h0;
                    if (cmd_sta)
                    begin
                        state_q <= S_START;
                    end
                    else if (cmd_sto && own_q)
                    begin
                        state_q <= S_STOP;
                    end
                    else if (launch)
                    begin
                        state_q <= S_BIT;
                        bit_q   <= 4'h0;
                        done_q  <= 7'h00;
                        shift_q <= buf_q[0];
                    end
                end
                S_START:
                begin
                    if (step)
                    begin
                        unique case (ph_q)
                            2'h0: sda_oen_q <= 1'b1;
                            2'h1: scl_oen_q <= 1'b1;
                            2'h2: sda_oen_q <= 1'b0;
                            2'h3:
                            begin
                                scl_oen_q <= 1'b0;
                                state_q   <= S_HOLD;
                                own_q     <= 1'b1;
                                addr_q    <= 1'b1;
                                rx_q      <= 1'b0;
                            end
                        endcase
                    end
                end
                S_BIT:
                begin
                    if (step)
                    begin
                        unique case (ph_q)
                            2'h0: sda_oen_q <= !drv_low;
                            2'h1: scl_oen_q <= 1'b1;
                            2'h2:
                            begin
                                if (lost)
                                begin
                                    state_q   <= S_IDLE;
                                    scl_oen_q <= 1'b1;
                                    sda_oen_q <= 1'b1;
                                    own_q     <= 1'b0;
                                end
                                else if (bit_q != 4'h8)
                                begin
                                    shift_q <= {shift_q[6:0], sda_s_q};
                                end
                                else
                                begin
                                    nack_q <= sda_s_q;
                                end
                            end
                            2'h3:
                            begin
                                scl_oen_q <= 1'b0;
                                if (bit_q != 4'h8)
                                begin
                                    bit_q <= 4'(bit_q + 4'h1);
                                end
                                else
                                begin
                                    bit_q  <= 4'h0;
                                    addr_q <= 1'b0;
                                    if (fin)
                                    begin
                                        state_q <= S_HOLD;
                                    end
                                    else if (to_rx)
                                    begin
                                        rx_q   <= 1'b1;
                                        done_q <= 7'h00;
                                    end
                                    else
                                    begin
                                        done_q <= 7'(done_q + 7'h01);
                                        if (!rx_q)
                                        begin
                                            shift_q <= buf_q[ptr_q];
                                        end
                                    end
                                end
                            end
                        endcase
                    end
                end
                S_STOP:
                begin
                    if (step)
                    begin
                        unique case (ph_q)
                            2'h0: sda_oen_q <= 1'b0;
                            2'h1: scl_oen_q <= 1'b1;
                            2'h2: sda_oen_q <= 1'b1;
                            2'h3:
                            begin
                                state_q <= S_IDLE;
                                own_q   <= 1'b0;
                                rx_q    <= 1'b0;
                            end
                        endcase
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Buffer pointer.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ptr_q <= 7'h00;
        end
        else if (launch)
        begin
            ptr_q <= (rx_q && !addr_q) ? 7'h00 : 7'h01;
        end
        else if (byte_end)
        begin
            if (rx_q && fin)
            begin
                ptr_q <= 7'h00;
            end
            else if (to_rx)
            begin
                ptr_q <= 7'h00;
            end
            else if (!fin)
            begin
                ptr_q <= ptr_next(ptr_q);
            end
        end
        else if (host_cnt)
        begin
            ptr_q <= 7'h00;
        end
        else if (data_acc && ready)
        begin
            ptr_q <= ptr_next(ptr_q);
        end
    end

    // Buffer storage.
    always_ff @(posedge mclk)
    begin
        if (byte_end && rx_q)
        begin
            buf_q[ptr_q] <= shift_q;
        end
        else if (req.wr && hit(req, OFS_DATA) && ready)
        begin
            buf_q[ptr_q] <= req.wdata;
        end
    end

    // Byte count register.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            count_q <= COUNT_RESET;
        end
        else if (fin_cnt_en)
        begin
            count_q[6:0] <= fin_cnt;
        end
        else if (host_cnt)
        begin
            count_q <= req.wdata;
        end
    end

    // Status register.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            status_q <= STS_IDLE;
        end
        else if (fin)
        begin
            status_q <= fin_sts;
        end
        else if (stop_done)
        begin
            status_q <= STS_IDLE;
        end
    end

    // Interrupt flag and mode bit; a hardware set wins over a clear.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            si_q   <= 1'b0;
            mode_q <= 1'b0;
        end
        else
        begin
            if (fin)
            begin
                si_q <= 1'b1;
            end
            else if (host_ctl && !req.wdata[CTL_SI])
            begin
                si_q <= 1'b0;
            end
            if (host_ctl)
            begin
                mode_q <= req.wdata[CTL_MODE];
            end
        end
    end

    // Read data, valid in the cycle after the read strobe.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rd_data_q <= 8'h00;
        end
        else if (req.rd)
        begin
            unique case (req.addr)
                OFS_STATUS: rd_data_q <= status_q;
                OFS_DATA:   rd_data_q <= buf_q[ptr_q];
                OFS_CTRL:   rd_data_q <= {4'h0, si_q, 2'h0, mode_q};
                OFS_COUNT:  rd_data_q <= count_q;
            endcase
        end
        else
        begin
            rd_data_q <= 8'h00;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_CNT_PTR: assert property (host_cnt && ready |=> ptr_q == 7'h00)
        else $error("pointer not reset by count write");
    AST_PTR_ADV: assert property (data_acc && ready
        |=> ptr_q == ptr_next($past(ptr_q)))
        else $error("pointer did not advance");
    AST_PTR_RANGE: assert property (ptr_q <= BUF_LAST)
        else $error("pointer beyond buffer");
    AST_BAD_CNT: assert property (cmd_go && bad_cnt
        |=> si_q && status_q == STS_BAD_COUNT && state_q == $past(state_q))
        else $error("invalid count not rejected");
    AST_TX_FIRST: assert property (launch && !(rx_q && !addr_q)
        |=> ptr_q == 7'h01 && state_q == S_BIT)
        else $error("transmit did not start at location zero");
    AST_RX_DONE: assert property (byte_end && rx_q && fin
        |=> ptr_q == 7'h00 && count_q[6:0] == $past(fin_cnt))
        else $error("receive completion wrong");
    AST_LB_KEEP: assert property (fin_cnt_en
        |=> $stable(count_q[CNT_LB]))
        else $error("last-byte flag lost");
    AST_HOLD_LOW: assert property (state_q == S_HOLD |-> !scl_oen_q)
        else $error("clock not held low");
    AST_TX_CNT: assert property (byte_end && !rx_q && nack_q
        |=> count_q[6:0] == 7'($past(done_q) + 7'h01) && si_q)
        else $error("transmit count wrong after nack");
    AST_LOST_ADDR: assert property (lost && addr_q
        |=> count_q[6:0] == 7'h00 && status_q == STS_ARB_LOST && !own_q)
        else $error("address arbitration loss wrong");
    AST_RX_NACK: assert property (byte_end && rx_q && last_byte
        && count_q[CNT_LB] |=> status_q == STS_RX_NACK && si_q
        && state_q == S_HOLD)
        else $error("nacked receive end wrong");
    AST_RX_ACKBIT: assert property (state_q == S_BIT && rx_q
        && bit_q == 4'h8 && ph_q == 2'h1 && !(last_byte && count_q[CNT_LB])
        |-> !sda_oen_q)
        else $error("receive acknowledge not driven");
    AST_RESTART: assert property (cmd_sta && own_q |=> state_q == S_START
        ##[1:300] (state_q == S_HOLD && status_q == STS_RESTART && si_q))
        else $error("repeated start not reported");
    AST_STOP: assert property (cmd_sto && own_q
        |=> (state_q == S_STOP && !si_q)[*8]
        ##[1:300] (state_q == S_IDLE && status_q == STS_IDLE && !si_q))
        else $error("stop sequence wrong");

    COV_RESTART: cover property (start_done && own_q);
    COV_RX_NACK: cover property (byte_end && rx_q && fin && count_q[CNT_LB]);
    COV_BAD_CNT: cover property (cmd_go && bad_cnt);
    COV_LOST: cover property (lost);

endmodule // ibc_ctrl

// File: hdl/ibc_pkg.sv
package ibc_pkg;

    // Data buffer geometry.
    localparam int         BUF_DEPTH = 68;
    localparam logic [6:0] BUF_LAST  = 7'h43;
    localparam logic [6:0] CNT_MAX   = 7'h44;

    // Register offsets on the plain register port.
    localparam logic [1:0] OFS_STATUS = 2'h0;
    localparam logic [1:0] OFS_DATA   = 2'h1;
    localparam logic [1:0] OFS_CTRL   = 2'h2;
    localparam logic [1:0] OFS_COUNT  = 2'h3;

    // Field positions in control_reg and transfer_byte_count.
    localparam int CTL_STA  = 5;
    localparam int CTL_STO  = 4;
    localparam int CTL_SI   = 3;
    localparam int CTL_MODE = 0;
    localparam int CNT_LB   = 7;

    // Reset values.
    localparam logic [7:0] COUNT_RESET = 8'h00;

    // Status codes.
    localparam logic [7:0] STS_START     = 8'h08;
    localparam logic [7:0] STS_RESTART   = 8'h10;
    localparam logic [7:0] STS_ADDR_ACK  = 8'h18;
    localparam logic [7:0] STS_ADDR_NACK = 8'h20;
    localparam logic [7:0] STS_DATA_ACK  = 8'h28;
    localparam logic [7:0] STS_DATA_NACK = 8'h30;
    localparam logic [7:0] STS_ARB_LOST  = 8'h38;
    localparam logic [7:0] STS_RADR_NACK = 8'h48;
    localparam logic [7:0] STS_RX_ACK    = 8'h50;
    localparam logic [7:0] STS_RX_NACK   = 8'h58;
    localparam logic [7:0] STS_IDLE      = 8'hf8;
    localparam logic [7:0] STS_BAD_COUNT = 8'hfc;

    // Serial timing: one bit is four quarter phases.
    localparam int         CLK_MHZ = 100;
    localparam int         QTR_NS  = 250;
    localparam int         QTR_CYC = (QTR_NS * CLK_MHZ + 999) / 1000;
    localparam logic [4:0] QTR_LAST = 5'(QTR_CYC - 1);

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_START = 3'b001,
        S_BIT   = 3'b011,
        S_HOLD  = 3'b010,
        S_STOP  = 3'b110
    } ibc_state_t;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ibc_req_t;

endpackage

// File: tb/ibc_slave_model.sv
`timescale 1ns/1ns
module ibc_slave_model (
    input  wire logic       scl,
    input  wire logic       sda,
    output logic            sda_pull,
    output logic [7:0]      addr_seen,
    output logic            mst_ack_n
);
    logic [3:0] bitn = 4'ha;
    logic [7:0] sh;
    logic [7:0] tx;
    logic       first;
    logic       rd_mode;
    initial sda_pull = 1'b0;
    always @(negedge sda)
        if (scl)
        begin
            bitn = 4'h0;
            first = 1'b1;
            rd_mode = 1'b0;
            tx = 8'hc0;
        end
    always @(posedge sda)
        if (scl)
            bitn = 4'ha;
    always @(posedge scl)
    begin
        if (bitn < 4'h8)
            sh = {sh[6:0], sda};
        if (bitn == 4'h8)
            mst_ack_n = sda;
        if (bitn == 4'h8 && rd_mode && sda)
            bitn = 4'ha;
        else if (bitn < 4'h9)
            bitn = bitn + 4'h1;
    end
    always @(negedge scl)
    begin
        if (bitn == 4'h8)
        begin
            if (rd_mode && !first)
                tx = tx + 8'h01;
            if (first)
                rd_mode = sh[0];
            if (first)
                addr_seen = sh;
            sda_pull = first ? (sh[7:1] == 7'h50) : !rd_mode;
            first = 1'b0;
        end
        else if (bitn == 4'h9)
            bitn = 4'h0;
        if (bitn < 4'h8)
            sda_pull = (rd_mode && !first) ? !tx[3'(7 - bitn)] : 1'b0;
    end
endmodule // ibc_slave_model

// File: tb/ibc_ctrl_tb.sv
`timescale 1ns/1ns
module ibc_ctrl_tb;
    import ibc_pkg::*;
    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    ibc_req_t   req = '0;
    logic [7:0] rd_data;
    logic [7:0] addr_seen;
    logic [7:0] v;
    logic       irq;
    logic       scl_o;
    logic       scl_oe_n;
    logic       sda_o;
    logic       sda_oe_n;
    logic       pull;
    logic       mst_ack_n;
    wire logic  scl = scl_oe_n | scl_o;
    wire logic  sda = (sda_oe_n | sda_o) & ~pull;
    int         failures = 0;
    int         n_checks = 0;
    logic [1:0] row_a [3] = '{OFS_STATUS, OFS_COUNT, OFS_CTRL};
    logic [7:0] row_e [3] = '{STS_IDLE, COUNT_RESET, 8'h00};
    logic [7:0] bad [3] = '{8'h00, 8'h45, 8'hff};
    always #5 mclk = ~mclk;
    ibc_ctrl dut (.mclk(mclk), .rst(rst), .req(req), .rd_data(rd_data),
        .irq(irq), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
    ibc_slave_model slave (.scl(scl), .sda(sda), .sda_pull(pull),
        .addr_seen(addr_seen), .mst_ack_n(mst_ack_n));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req <= '0;
    endtask
    task automatic rchk(input logic [1:0] a, input logic [7:0] e);
        @(posedge mclk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        req <= '0;
        #1 v = rd_data;
        chk(v, e);
    endtask
    task automatic wait_irq;
        int i;
        repeat (3) @(posedge mclk);
        for (i = 0; i < 20000 && irq !== 1'b1; i++)
            @(posedge mclk);
        chk({7'h00, irq}, 8'h01);
    endtask
    task automatic complete_run;
        if (failures == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #800000;
        failures++;
        complete_run();
    end
    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        for (int r = 0; r < 3; r++)
            rchk(row_a[r], row_e[r]);
        chk({6'h00, scl_oe_n, sda_oe_n}, 8'h03);
        wr(OFS_COUNT, 8'h01);
        for (int i = 0; i <= 68; i++)
            wr(OFS_DATA, 8'(i));
        wr(OFS_COUNT, 8'h01);
        rchk(OFS_DATA, 8'h44);
        rchk(OFS_DATA, 8'h01);
        wr(OFS_COUNT, 8'h02);
        wr(OFS_DATA, 8'ha0);
        wr(OFS_DATA, 8'h08);
        wr(OFS_CTRL, 8'h20);
        wait_irq();
        rchk(OFS_STATUS, STS_START);
        for (int k = 0; k < 3; k++)
        begin
            wr(OFS_COUNT, bad[k]);
            wr(OFS_CTRL, 8'h01);
            wait_irq();
            rchk(OFS_STATUS, STS_BAD_COUNT);
        end
        wr(OFS_COUNT, 8'h02);
        wr(OFS_CTRL, 8'h01);
        wait_irq();
        rchk(OFS_STATUS, STS_DATA_ACK);
        rchk(OFS_COUNT, 8'h02);
        chk(addr_seen, 8'ha0);
        chk({7'h00, scl_oe_n}, 8'h00);
        wr(OFS_COUNT, 8'h04);
        wr(OFS_DATA, 8'ha1);
        wr(OFS_CTRL, 8'h20);
        wait_irq();
        rchk(OFS_STATUS, STS_RESTART);
        for (int s = 0; s < 2; s++)
        begin
            if (s == 1)
                wr(OFS_COUNT, 8'h84);
            wr(OFS_CTRL, 8'h01);
            wait_irq();
            rchk(OFS_STATUS, s ? STS_RX_NACK : STS_RX_ACK);
            rchk(OFS_COUNT, s ? 8'h84 : 8'h04);
            chk({7'h00, scl_oe_n}, 8'h00);
            chk({7'h00, mst_ack_n}, 8'(s));
            for (int b = 0; b < 4; b++)
                rchk(OFS_DATA, 8'hc0 + 8'(4 * s + b));
        end
        wr(OFS_COUNT, 8'h01);
        wr(OFS_DATA, 8'hb0);
        wr(OFS_CTRL, 8'h20);
        wait_irq();
        wr(OFS_CTRL, 8'h01);
        wait_irq();
        rchk(OFS_STATUS, STS_ADDR_NACK);
        rchk(OFS_COUNT, 8'h01);
        wr(OFS_CTRL, 8'h10);
        repeat (300) @(posedge mclk);
        chk({6'h00, irq, scl_oe_n & sda_oe_n}, 8'h01);
        rchk(OFS_STATUS, STS_IDLE);
        complete_run();
    end
endmodule // ibc_ctrl_tb
